// ===== rtl/hcs_sampler.sv
// two-channel heater current sampling sequencer with avalon-mm registers
`timescale 1ns/1ps
module hcs_sampler #(
   parameter int CHANNELS = 2,
   parameter int CUR_W = 12,
   parameter int TICK_CYC = hcs_pkg::TICK_CYC
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [4:0] mon_outputs,
   input wire logic [CUR_W-1:0] ct1_sample,
   input wire logic [CUR_W-1:0] ct2_sample,
   output logic [CUR_W-1:0] on_cur_1,
   output logic [CUR_W-1:0] off_cur_1,
   output logic on_valid_1,
   output logic off_valid_1,
   output logic [CUR_W-1:0] disp_cur_1,
   output logic [CUR_W-1:0] on_cur_2,
   output logic [CUR_W-1:0] off_cur_2,
   output logic on_valid_2,
   output logic off_valid_2,
   output logic [CUR_W-1:0] disp_cur_2
);
   localparam int TC_W = $clog2(TICK_CYC + 1);

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);

   // millisecond tick shared by both channels
   logic [TC_W-1:0] tick_cnt_r;
   logic [TC_W-1:0] tick_cnt_nxt;
   logic tick_r;
   logic tick_nxt;

   always_comb begin
      tick_nxt = 1'b0;
      tick_cnt_nxt = tick_cnt_r + TC_W'(1);
      if (tick_cnt_r == TC_W'(TICK_CYC - 1)) begin
         tick_cnt_nxt = '0;
         tick_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         tick_cnt_r <= '0;
         tick_r <= 1'b0;
      end else begin
         tick_cnt_r <= tick_cnt_nxt;
         tick_r <= tick_nxt;
      end
   end

   // per-channel state, sized for two so absent channels read as zero, bar their idle code in status
   hcs_pkg::hcs_state_t st_r [2];
   hcs_pkg::hcs_state_t st_nxt [2];
   logic [8:0] cnt_r [2];
   logic [8:0] cnt_nxt [2];
   logic mode_r [2];
   logic mode_nxt [2];
   logic mode_d_r [2];
   logic mode_d_nxt [2];
   logic [2:0] sel_r [2];
   logic [2:0] sel_nxt [2];
   logic [8:0] dly_r [2];
   logic [8:0] dly_nxt [2];
   logic lvl_r [2];
   logic lvl_nxt [2];
   logic phase_r [2];
   logic phase_nxt [2];
   logic [CUR_W-1:0] peak_r [2];
   logic [CUR_W-1:0] peak_nxt [2];
   logic [CUR_W-1:0] on_r [2];
   logic [CUR_W-1:0] on_nxt [2];
   logic [CUR_W-1:0] off_r [2];
   logic [CUR_W-1:0] off_nxt [2];
   logic [CUR_W-1:0] disp_r [2];
   logic [CUR_W-1:0] disp_nxt [2];
   logic on_v_r [2];
   logic on_v_nxt [2];
   logic off_v_r [2];
   logic off_v_nxt [2];
   logic [CUR_W-1:0] samp [2];
   logic cfg_we [2];
   logic wait_r;

   assign samp[0] = ct1_sample;
   assign samp[1] = ct2_sample;
   // a write lands on the edge where waitrequest is low
   assign cfg_we[0] = avs_write && !wait_r &&
                      (avs_address == hcs_pkg::REG_CFG1);
   assign cfg_we[1] = avs_write && !wait_r &&
                      (avs_address == hcs_pkg::REG_CFG2);

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_ch
         localparam bit PRESENT = (gi < CHANNELS);
         logic lvl;
         logic chg;
         logic [8:0] dly_w;
         logic [CUR_W-1:0] pk;

         always_comb begin
            lvl = mon_outputs[sel_r[gi]];
            chg = (lvl != lvl_r[gi]);
            pk = (samp[gi] > peak_r[gi]) ? samp[gi] : peak_r[gi];
            dly_w = {avs_byteenable[3] ? avs_writedata[24] : dly_r[gi][8],
                     avs_byteenable[2] ? avs_writedata[23:16] :
                     dly_r[gi][7:0]};
            st_nxt[gi] = st_r[gi];
            cnt_nxt[gi] = cnt_r[gi];
            mode_nxt[gi] = mode_r[gi];
            mode_d_nxt[gi] = mode_r[gi];
            sel_nxt[gi] = sel_r[gi];
            dly_nxt[gi] = dly_r[gi];
            lvl_nxt[gi] = lvl;
            phase_nxt[gi] = phase_r[gi];
            peak_nxt[gi] = peak_r[gi];
            on_nxt[gi] = on_r[gi];
            off_nxt[gi] = off_r[gi];
            on_v_nxt[gi] = 1'b0;
            off_v_nxt[gi] = 1'b0;
            if (cfg_we[gi] && avs_byteenable[0]) begin
               mode_nxt[gi] = avs_writedata[hcs_pkg::MODE_BIT];
               if (avs_writedata[hcs_pkg::SEL_LSB +: 3] <= hcs_pkg::SEL_MAX)
                  sel_nxt[gi] = avs_writedata[hcs_pkg::SEL_LSB +: 3];
            end
            if (cfg_we[gi] && (avs_byteenable[2] || avs_byteenable[3])) begin
               if (dly_w < hcs_pkg::DLY_MIN)
                  dly_nxt[gi] = hcs_pkg::DLY_MIN;
               else if (dly_w > hcs_pkg::DLY_MAX)
                  dly_nxt[gi] = hcs_pkg::DLY_MAX;
               else
                  dly_nxt[gi] = dly_w;
            end
            if (mode_r[gi] != mode_d_r[gi]) begin
               // a mode change drops any half-done measurement
               st_nxt[gi] = hcs_pkg::HCS_IDLE;
               cnt_nxt[gi] = '0;
               // clear a stale off result at once
               if (mode_r[gi] == hcs_pkg::MODE_MEAS)
                  off_nxt[gi] = '0;
            end else if (mode_r[gi] == hcs_pkg::MODE_MEAS) begin
               off_nxt[gi] = '0;
               case (st_r[gi])
                  hcs_pkg::HCS_IDLE: begin
                     if (tick_r) begin
                        st_nxt[gi] = hcs_pkg::HCS_MEAS;
                        cnt_nxt[gi] = '0;
                        peak_nxt[gi] = '0;
                     end
                  end
                  hcs_pkg::HCS_MEAS: begin
                     peak_nxt[gi] = pk;
                     if (tick_r) begin
                        cnt_nxt[gi] = cnt_r[gi] + 9'h001;
                        if (cnt_r[gi] == hcs_pkg::MEAS_TICKS - 9'h001) begin
                           on_nxt[gi] = pk;
                           on_v_nxt[gi] = 1'b1;
                           cnt_nxt[gi] = '0;
                           peak_nxt[gi] = '0;
                        end
                     end
                  end
                  default: st_nxt[gi] = hcs_pkg::HCS_IDLE;
               endcase
            end else if (chg) begin
               st_nxt[gi] = hcs_pkg::HCS_WAIT;
               cnt_nxt[gi] = '0;
               phase_nxt[gi] = lvl;
            end else begin
               case (st_r[gi])
                  hcs_pkg::HCS_IDLE: st_nxt[gi] = hcs_pkg::HCS_IDLE;
                  hcs_pkg::HCS_WAIT: begin
                     if (tick_r) begin
                        cnt_nxt[gi] = cnt_r[gi] + 9'h001;
                        if (cnt_r[gi] == dly_r[gi]) begin
                           st_nxt[gi] = hcs_pkg::HCS_MEAS;
                           cnt_nxt[gi] = '0;
                           peak_nxt[gi] = '0;
                        end
                     end
                  end
                  hcs_pkg::HCS_MEAS: begin
                     peak_nxt[gi] = pk;
                     if (tick_r) begin
                        cnt_nxt[gi] = cnt_r[gi] + 9'h001;
                        if (cnt_r[gi] == hcs_pkg::MEAS_TICKS - 9'h001) begin
                           st_nxt[gi] = hcs_pkg::HCS_IDLE;
                           cnt_nxt[gi] = '0;
                           if (phase_r[gi]) begin
                              on_nxt[gi] = pk;
                              on_v_nxt[gi] = 1'b1;
                           end else begin
                              off_nxt[gi] = pk;
                              off_v_nxt[gi] = 1'b1;
                           end
                        end
                     end
                  end
                  default: st_nxt[gi] = hcs_pkg::HCS_IDLE;
               endcase
            end
            disp_nxt[gi] = on_nxt[gi];
            if (!PRESENT) begin
               st_nxt[gi] = hcs_pkg::HCS_IDLE;
               cnt_nxt[gi] = '0;
               mode_nxt[gi] = hcs_pkg::MODE_BURN;
               mode_d_nxt[gi] = hcs_pkg::MODE_BURN;
               sel_nxt[gi] = hcs_pkg::SEL_RST;
               dly_nxt[gi] = hcs_pkg::DLY_RST;
               lvl_nxt[gi] = 1'b0;
               phase_nxt[gi] = 1'b0;
               peak_nxt[gi] = '0;
               on_nxt[gi] = '0;
               off_nxt[gi] = '0;
               disp_nxt[gi] = '0;
               on_v_nxt[gi] = 1'b0;
               off_v_nxt[gi] = 1'b0;
            end
         end

         always_ff @(posedge clk_sys or negedge rst_b) begin
            if (!rst_b) begin
               st_r[gi] <= hcs_pkg::HCS_IDLE;
               cnt_r[gi] <= '0;
               mode_r[gi] <= hcs_pkg::MODE_BURN;
               mode_d_r[gi] <= hcs_pkg::MODE_BURN;
               sel_r[gi] <= hcs_pkg::SEL_RST;
               dly_r[gi] <= hcs_pkg::DLY_RST;
               lvl_r[gi] <= 1'b0;
               phase_r[gi] <= 1'b0;
               peak_r[gi] <= '0;
               on_r[gi] <= '0;
               off_r[gi] <= '0;
               disp_r[gi] <= '0;
               on_v_r[gi] <= 1'b0;
               off_v_r[gi] <= 1'b0;
            end else begin
               st_r[gi] <= st_nxt[gi];
               cnt_r[gi] <= cnt_nxt[gi];
               mode_r[gi] <= mode_nxt[gi];
               mode_d_r[gi] <= mode_d_nxt[gi];
               sel_r[gi] <= sel_nxt[gi];
               dly_r[gi] <= dly_nxt[gi];
               lvl_r[gi] <= lvl_nxt[gi];
               phase_r[gi] <= phase_nxt[gi];
               peak_r[gi] <= peak_nxt[gi];
               on_r[gi] <= on_nxt[gi];
               off_r[gi] <= off_nxt[gi];
               disp_r[gi] <= disp_nxt[gi];
               on_v_r[gi] <= on_v_nxt[gi];
               off_v_r[gi] <= off_v_nxt[gi];
            end
         end

         property p_one_result;
            !(on_v_r[gi] && off_v_r[gi]);
         endproperty
         a_one_result: assert property (p_one_result)
            else $error("both results committed at once");

         property p_disp_on;
            on_v_r[gi] |-> (disp_r[gi] == on_r[gi]) ##1 (disp_r[gi] == on_r[gi]);
         endproperty
         a_disp_on: assert property (p_disp_on)
            else $error("display differs from on result");

         property p_on_phase;
            on_v_r[gi] |-> ($past(mode_r[gi]) || $past(phase_r[gi]));
         endproperty
         a_on_phase: assert property (p_on_phase)
            else $error("on result taken in off phase");

         property p_off_phase;
            off_v_r[gi] |-> (!$past(phase_r[gi]) && !$past(mode_r[gi]));
         endproperty
         a_off_phase: assert property (p_off_phase)
            else $error("off result taken in on phase or measure mode");

         property p_off_zero;
            (mode_r[gi] && $past(mode_r[gi])) |-> (off_r[gi] == '0);
         endproperty
         a_off_zero: assert property (p_off_zero)
            else $error("off result not zero in measure mode");

         property p_sel_range;
            (sel_r[gi] <= hcs_pkg::SEL_MAX) &&
            (dly_r[gi] >= hcs_pkg::DLY_MIN) && (dly_r[gi] <= hcs_pkg::DLY_MAX);
         endproperty
         a_sel_range: assert property (p_sel_range)
            else $error("config field out of range");

         property p_no_wait_meas;
            (mode_r[gi] && $past(mode_r[gi])) |-> (st_r[gi] != hcs_pkg::HCS_WAIT);
         endproperty
         a_no_wait_meas: assert property (p_no_wait_meas)
            else $error("wait entered in measure mode");

         property p_wait_end;
            (st_r[gi] == hcs_pkg::HCS_WAIT && tick_r && !chg && !mode_r[gi] &&
             mode_r[gi] == mode_d_r[gi] && cnt_r[gi] == dly_r[gi])
            |=> (st_r[gi] == hcs_pkg::HCS_MEAS) && (cnt_r[gi] == '0);
         endproperty
         a_wait_end: assert property (p_wait_end)
            else $error("measurement did not start after wait");

         property p_commit;
            (st_r[gi] == hcs_pkg::HCS_MEAS && tick_r && !chg && !mode_r[gi] &&
             mode_r[gi] == mode_d_r[gi] &&
             cnt_r[gi] == hcs_pkg::MEAS_TICKS - 9'h001)
            |=> (on_v_r[gi] || off_v_r[gi]) && (st_r[gi] == hcs_pkg::HCS_IDLE);
         endproperty
         a_commit: assert property (p_commit)
            else $error("window end did not commit");

         property p_abandon;
            (st_r[gi] != hcs_pkg::HCS_IDLE && chg && !mode_r[gi] &&
             mode_r[gi] == mode_d_r[gi] && PRESENT)
            |=> (st_r[gi] == hcs_pkg::HCS_WAIT) && !on_v_r[gi] && !off_v_r[gi];
         endproperty
         a_abandon: assert property (p_abandon)
            else $error("transition did not restart wait");
      end
   endgenerate

   // avalon slave: one wait cycle, then a single-cycle answer
   logic wait_nxt;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;

   always_comb begin
      wait_nxt = 1'b1;
      rdata_nxt = rdata_r;
      if ((avs_read || avs_write) && wait_r) begin
         wait_nxt = 1'b0;
         if (avs_read) begin
            rdata_nxt = '0;
            case (avs_address)
               hcs_pkg::REG_CFG1, hcs_pkg::REG_CFG2: begin
                  if (avs_address == hcs_pkg::REG_CFG1 || CHANNELS > 1) begin
                     rdata_nxt[hcs_pkg::MODE_BIT] = mode_r[avs_address[2]];
                     rdata_nxt[hcs_pkg::SEL_LSB +: 3] = sel_r[avs_address[2]];
                     rdata_nxt[hcs_pkg::DLY_LSB +: 9] = dly_r[avs_address[2]];
                  end
               end
               hcs_pkg::REG_CUR1: rdata_nxt[CUR_W-1:0] = disp_r[0];
               hcs_pkg::REG_CUR2: rdata_nxt[CUR_W-1:0] = disp_r[1];
               hcs_pkg::REG_STAT: begin
                  for (int k = 0; k < 2; k++) begin
                     rdata_nxt[k*hcs_pkg::STAT_STRIDE +: 4] =
                        {lvl_r[k], st_r[k]};
                  end
               end
               default: rdata_nxt = '0;
            endcase
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         wait_r <= 1'b1;
         rdata_r <= '0;
      end else begin
         wait_r <= wait_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   property p_absent_reads_zero;
      (CHANNELS < 2 && avs_read && !avs_waitrequest &&
       avs_address == hcs_pkg::REG_CFG2) |-> (avs_readdata == '0);
   endproperty
   a_absent_reads_zero: assert property (p_absent_reads_zero)
      else $error("absent channel config visible");

   assign avs_waitrequest = wait_r;
   assign avs_readdata = rdata_r;
   assign on_cur_1 = on_r[0];
   assign off_cur_1 = off_r[0];
   assign on_valid_1 = on_v_r[0];
   assign off_valid_1 = off_v_r[0];
   assign disp_cur_1 = disp_r[0];
   assign on_cur_2 = on_r[1];
   assign off_cur_2 = off_r[1];
   assign on_valid_2 = on_v_r[1];
   assign off_valid_2 = off_v_r[1];
   assign disp_cur_2 = disp_r[1];
endmodule

// ===== rtl/hcs_pkg.sv
// constants and types shared by the heater current sampler
package hcs_pkg;
   // clock rate and the millisecond tick derived from it
   localparam int CLK_MHZ = 125;
   localparam int TICK_US = 1000;
   localparam int TICK_CYC = CLK_MHZ * TICK_US;

   // measurement window, in ms, and its length in ticks
   localparam int MEAS_MS = 100;
   localparam logic [8:0] MEAS_TICKS = 9'(MEAS_MS * 1000 / TICK_US);

   // settle delay limits and reset value, in ms
   localparam logic [8:0] DLY_MIN = 9'h014;
   localparam logic [8:0] DLY_MAX = 9'h12c;
   localparam logic [8:0] DLY_RST = 9'h01e;

   // watched output code: 0..1 control outputs, 2..4 event outputs
   localparam logic [2:0] SEL_MAX = 3'h4;
   localparam logic [2:0] SEL_RST = 3'h0;

   // sense mode values
   localparam logic MODE_BURN = 1'b0;
   localparam logic MODE_MEAS = 1'b1;

   // register byte offsets
   localparam logic [4:0] REG_CFG1 = 5'h00;
   localparam logic [4:0] REG_CFG2 = 5'h04;
   localparam logic [4:0] REG_CUR1 = 5'h08;
   localparam logic [4:0] REG_CUR2 = 5'h0c;
   localparam logic [4:0] REG_STAT = 5'h10;

   // field positions in a config register, and the status field stride
   localparam int MODE_BIT = 0;
   localparam int SEL_LSB = 4;
   localparam int DLY_LSB = 16;
   localparam int STAT_STRIDE = 4;

   typedef enum logic [2:0] {
      HCS_IDLE = 3'b001,
      HCS_WAIT = 3'b010,
      HCS_MEAS = 3'b100
   } hcs_state_t;
endpackage

// ===== dv/hcs_ct_model.sv
// behavioural current transformer front end and monitored outputs
`timescale 1ns/1ps
module hcs_ct_model #(
   parameter int CUR_W = 12
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic [4:0] drive_lvl,
   input wire logic [2:0] watch_1,
   input wire logic [2:0] watch_2,
   input wire logic [CUR_W-1:0] heat_1,
   input wire logic [CUR_W-1:0] leak_1,
   input wire logic [CUR_W-1:0] heat_2,
   input wire logic [CUR_W-1:0] leak_2,
   output logic [4:0] mon_outputs,
   output logic [CUR_W-1:0] ct1_sample,
   output logic [CUR_W-1:0] ct2_sample
);
   // heater current flows only while its output is on, leakage otherwise;
   // the sample lags the output by a cycle as a real transformer would
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         mon_outputs <= 5'h00;
         ct1_sample <= '0;
         ct2_sample <= '0;
      end else begin
         mon_outputs <= drive_lvl;
         ct1_sample <= mon_outputs[watch_1] ? heat_1 : leak_1;
         ct2_sample <= mon_outputs[watch_2] ? heat_2 : leak_2;
      end
   end
endmodule

// ===== dv/tb.sv
// self-checking bench for the heater current sampler
`timescale 1ns/1ps
module tb;
   localparam int TICK = 10;
   localparam int CW = 12;
   localparam int LIMIT = 30000;
   logic clk_sys, rst_b, avs_read, avs_write, avs_waitrequest;
   logic [4:0] avs_address, mon_outputs, drive_lvl;
   logic [31:0] avs_writedata, avs_readdata;
   logic [3:0] avs_byteenable;
   logic [CW-1:0] ct1_sample, ct2_sample, heat_1, leak_1, heat_2, leak_2;
   logic [CW-1:0] on_cur_1, off_cur_1, disp_cur_1;
   logic [CW-1:0] on_cur_2, off_cur_2, disp_cur_2;
   logic on_valid_1, off_valid_1, on_valid_2, off_valid_2;
   int mismatches, check_count, cyc, on_n1, off_n1, on_n2, off_n2;
   logic [31:0] rd_one, q_one;
   logic wt_one;

   hcs_sampler #(.CHANNELS(2), .CUR_W(CW), .TICK_CYC(TICK)) dut_u (
      .clk_sys(clk_sys), .rst_b(rst_b), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .mon_outputs(mon_outputs), .ct1_sample(ct1_sample),
      .ct2_sample(ct2_sample), .on_cur_1(on_cur_1), .off_cur_1(off_cur_1),
      .on_valid_1(on_valid_1), .off_valid_1(off_valid_1),
      .disp_cur_1(disp_cur_1), .on_cur_2(on_cur_2), .off_cur_2(off_cur_2),
      .on_valid_2(on_valid_2), .off_valid_2(off_valid_2),
      .disp_cur_2(disp_cur_2));

   // one-channel build on the same bus, answers in step with dut_u
   hcs_sampler #(.CHANNELS(1), .CUR_W(CW), .TICK_CYC(TICK)) dut_one_u (
      .clk_sys(clk_sys), .rst_b(rst_b), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(rd_one), .avs_waitrequest(wt_one),
      .mon_outputs(mon_outputs), .ct1_sample(ct1_sample),
      .ct2_sample(ct2_sample), .on_cur_1(), .off_cur_1(),
      .on_valid_1(), .off_valid_1(), .disp_cur_1(), .on_cur_2(),
      .off_cur_2(), .on_valid_2(), .off_valid_2(), .disp_cur_2());

   hcs_ct_model #(.CUR_W(CW)) far_u (
      .clk_sys(clk_sys), .rst_b(rst_b), .drive_lvl(drive_lvl),
      .watch_1(3'h2), .watch_2(3'h3), .heat_1(heat_1), .leak_1(leak_1),
      .heat_2(heat_2), .leak_2(leak_2), .mon_outputs(mon_outputs),
      .ct1_sample(ct1_sample), .ct2_sample(ct2_sample));

   task give_verdict;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] seen,
                      input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // one avalon access: hold everything until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [4:0] a,
                      input logic [31:0] d, input logic [3:0] be,
                      output logic [31:0] q);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_write <= wr;
      avs_read <= !wr;
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0 && n < 50) begin
         @(posedge clk_sys);
         n++;
      end
      q = avs_readdata;
      q_one = rd_one;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk_sys);
      if (n >= 50)
         mismatches++;
   endtask

   task automatic wr(input logic [4:0] a, input logic [31:0] d,
                     input logic [3:0] be);
      logic [31:0] q;
      bus(1'b1, a, d, be, q);
   endtask

   task automatic rdc(input string what, input logic [4:0] a,
                      input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, 4'hf, q);
      chk(what, q, exp);
   endtask

   // idx 0 on1, 1 off1, 2 on2, 3 off2; checks the cycle count to the pulse
   task automatic wait_evt(input int idx, input int lo, input int hi);
      int n;
      logic [3:0] v;
      n = 0;
      v = 4'h0;
      while (v[idx] !== 1'b1 && n < hi + 4) begin
         @(posedge clk_sys);
         n++;
         v = {off_valid_2, on_valid_2, off_valid_1, on_valid_1};
      end
      chk("commit_time", 32'(n >= lo && n <= hi), 32'h1);
   endtask

   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (on_valid_1 === 1'b1) on_n1 <= on_n1 + 1;
      if (off_valid_1 === 1'b1) off_n1 <= off_n1 + 1;
      if (on_valid_2 === 1'b1) on_n2 <= on_n2 + 1;
      if (off_valid_2 === 1'b1) off_n2 <= off_n2 + 1;
      if (cyc == LIMIT) begin
         mismatches = mismatches + 1;
         give_verdict();
      end
   end

   initial begin
      {mismatches, check_count, cyc, on_n1, off_n1, on_n2, off_n2} = '0;
      rst_b = 1'b0;
      avs_address = 5'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hf;
      drive_lvl = 5'h00;
      heat_1 = 12'h3a5;
      leak_1 = 12'h012;
      heat_2 = 12'h2c0;
      leak_2 = 12'h077;
      repeat (4) @(posedge clk_sys);
      rst_b <= 1'b1;
      @(posedge clk_sys);
      rdc("cfg1_rst", 5'h00, 32'h001e_0000);
      rdc("cfg2_rst", 5'h04, 32'h001e_0000);
      chk("cfg2_absent", q_one, 32'h0);
      rdc("stat_rst", 5'h10, 32'h0000_0011);
      wr(5'h14, 32'hffff_ffff, 4'hf);
      wr(5'h08, 32'h0000_0fff, 4'hf);
      rdc("unmapped", 5'h14, 32'h0);
      rdc("cur1_ro", 5'h08, 32'h0);
      // settle delay is clamped at both ends, bad watched code refused
      wr(5'h00, 32'h0005_0000, 4'hf);
      rdc("dly_low", 5'h00, 32'h0014_0000);
      wr(5'h00, 32'h0190_0000, 4'hf);
      rdc("dly_high", 5'h00, 32'h012c_0000);
      wr(5'h00, 32'h0000_0050, 4'hf);
      rdc("sel_bad", 5'h00, 32'h0014_0000);
      wr(5'h00, 32'h0190_0020, 4'h1);
      rdc("sel_lane", 5'h00, 32'h0014_0020);
      // burnout mode, on phase of event output 1
      drive_lvl <= 5'h04;
      repeat (5) @(posedge clk_sys);
      rdc("stat_wait", 5'h10, 32'h0000_001a);
      wait_evt(0, 120 * TICK - 8, 122 * TICK - 4);
      rdc("cur1_on", 5'h08, 32'h0000_03a5);
      chk("on1", 32'(on_cur_1), 32'h3a5);
      chk("disp1", 32'(disp_cur_1), 32'h3a5);
      chk("off1_quiet", 32'(off_cur_1), 32'h0);
      chk("off1_n0", 32'(off_n1), 32'h0);
      // off phase feeds only the off result
      drive_lvl <= 5'h00;
      wait_evt(1, 120 * TICK, 122 * TICK + 4);
      rdc("cur1_keep", 5'h08, 32'h0000_03a5);
      chk("off1", 32'(off_cur_1), 32'h012);
      chk("on1_keep", 32'(on_cur_1), 32'h3a5);
      chk("on1_n1", 32'(on_n1), 32'h1);
      // output falls in mid-measurement: on window is dropped
      leak_1 <= 12'h021;
      drive_lvl <= 5'h04;
      repeat (60 * TICK) @(posedge clk_sys);
      drive_lvl <= 5'h00;
      wait_evt(1, 120 * TICK, 122 * TICK + 4);
      rdc("cur1_abort", 5'h08, 32'h0000_03a5);
      chk("on1_n_abort", 32'(on_n1), 32'h1);
      chk("off1_new", 32'(off_cur_1), 32'h021);
      // channel 2 in plain measurement, long delay must be ignored
      wr(5'h04, 32'h012c_0041, 4'hf);
      wait_evt(2, 0, 102 * TICK + 4);
      wait_evt(2, 100 * TICK - 1, 100 * TICK + 1);
      drive_lvl <= 5'h18;
      wait_evt(2, 100 * TICK - 1, 100 * TICK + 1);
      wait_evt(2, 100 * TICK - 1, 100 * TICK + 1);
      rdc("cur2", 5'h0c, 32'h0000_02c0);
      chk("cur2_absent", q_one, 32'h0);
      rdc("cfg2_meas", 5'h04, 32'h012c_0041);
      chk("cfg2_absent_wr", q_one, 32'h0);
      chk("disp2", 32'(disp_cur_2), 32'h2c0);
      chk("off2_zero", 32'(off_cur_2), 32'h0);
      chk("off2_n0", 32'(off_n2), 32'h0);
      rdc("cfg1_indep", 5'h00, 32'h0014_0020);
      chk("on1_still", 32'(on_n1), 32'h1);
      give_verdict();
   end
endmodule
